// ===== rtl/system_control_block_regs.v
// Functional notes
// - identity register read-only fixed fields
// - write one pends nonmaskable exception
// - nonmaskable handler entry clears pending bit
// - write one pends pendable service
// - only software write pends pendable service
// - clear bit removes pendable service pending
// - write one pends system tick
// - clear bit removes system tick pending
// - preempt flag shows pending exception waiting, only while debug halted
// - interrupt pending flag excludes nonmaskable
// - pending vector shows highest enabled
// - active vector zero in thread mode
// - wake on pending includes disabled interrupts
// - pending entry wakes or latches event
// - send event or input wakes
// - deep sleep select chooses low power
// - sleep on return enters sleep
// - supervisor call priority two bits
// - tick and pendable service priorities
// - registers decoded from control space offsets
// - little endian data, bit zero lowest
`timescale 1ns/1ps
`include "sys_ctrl_defs.vh"

module system_control_block_regs #(
  parameter        NUM_IRQ      = 32,
  parameter [7:0]  IMPL_CODE    = 8'h5a,   // arbitrary value
  parameter [3:0]  ARCH_CODE    = 4'h3,    // arbitrary value
  parameter [11:0] PART_CODE    = 12'h123, // arbitrary value
  parameter [3:0]  REV_CODE     = 4'h1     // arbitrary value
) (
  input  wire               sys_clk,
  input  wire               rst,
  input  wire [11:0]        reg_addr,
  input  wire [31:0]        reg_wdata,
  input  wire               reg_wr,
  input  wire               reg_rd,
  output reg  [31:0]        reg_rdata,
  input  wire               nmi_req,
  input  wire               tick_event,
  input  wire [NUM_IRQ-1:0] irq_pending,
  input  wire [NUM_IRQ-1:0] irq_enabled,
  input  wire [NUM_IRQ-1:0] irq_prio_hi,
  input  wire               exc_enter,
  input  wire [8:0]         exc_enter_num,
  input  wire               exc_return,
  input  wire [8:0]         exc_return_to,
  input  wire               debug_halted,
  input  wire               sleep_req,
  // pulse: the core executes a wait-for-event instruction
  input  wire               wait_for_event_req,
  input  wire               send_event_instruction,
  input  wire               ext_event,
  output reg                sleeping,
  output reg                deep_sleep,
  output reg                wake_pulse,
  output reg                nmi_pend,
  output reg                psv_pend,
  output reg                tick_pend,
  output reg                event_latched,
  output reg  [1:0]         supervisor_call_priority,
  output reg  [1:0]         pendable_service_priority,
  output reg  [1:0]         tick_handler_priority
);

  // ****************************************************************
  // state
  // ****************************************************************
  localparam [1:0] ST_RUN   = 2'b01;
  localparam [1:0] ST_SLEEP = 2'b10;

  // the sleep machine has two states only; the core itself stalls
  // while sleeping is high, so no state for the wake-up latency is kept
  // here. deep sleep is not a state of its own: it is the same sleep
  // with the depth select shown on a separate output, so the clock
  // controller outside decides what deep sleep actually switches off.
  reg [1:0] state_ff;
  reg       wake_on_pending_ff;
  reg       deep_sleep_select_ff;
  reg       sleep_on_return_ff;
  reg [8:0] active_vector_ff;
  // remembers which kind of sleep was entered, since the wake sources
  // differ: wait-for-interrupt wakes on pending work, wait-for-event
  // wakes on events and on the latched event flag
  reg       wait_event_mode_ff;
  reg [NUM_IRQ-1:0] irq_pend_prev_ff;

  // ****************************************************************
  // decode
  // ****************************************************************
  // the control space base is stripped before this block, so only the
  // low twelve address bits are compared; a full decode would need the
  // base comparator duplicated in every register bank of the space.
  // the identity register has no write decode at all, so writes to it
  // cannot disturb anything.
  wire wr_pend  = reg_wr && (reg_addr == `OFS_EXC_PEND_STATE);
  wire wr_sleep = reg_wr && (reg_addr == `OFS_SLEEP_CONTROL);
  wire wr_pra   = reg_wr && (reg_addr == `OFS_HANDLER_PRIO_A);
  wire wr_prb   = reg_wr && (reg_addr == `OFS_HANDLER_PRIO_B);

  // ****************************************************************
  // pending vector search
  // ****************************************************************
  // the interrupt controller only hands over a one-bit priority tag per
  // line: tagged lines rank as priority zero, untagged as priority three.
  // the middle two levels are therefore not resolved here; a limitation
  // accepted to keep the search to two plain priority-encoder passes.
  // per-irq qualifier: pending, enabled; high-priority tag wins first
  wire [NUM_IRQ-1:0] irq_ready = irq_pending & irq_enabled;
  wire [NUM_IRQ-1:0] irq_hi    = irq_ready & irq_prio_hi;

  reg [8:0] irq_vec;
  reg       irq_found;
  integer   i;
  // lowest number wins among equals; the high-priority tag pass goes last so it overrides
  always @* begin
    irq_vec   = 9'h000;
    irq_found = 1'b0;
    for (i = NUM_IRQ - 1; i >= 0; i = i - 1) begin
      if (irq_ready[i]) begin
        irq_vec   = `EXC_IRQ_BASE + i[8:0];
        irq_found = 1'b1;
      end
    end
    for (i = NUM_IRQ - 1; i >= 0; i = i - 1) begin
      if (irq_hi[i]) begin
        irq_vec = `EXC_IRQ_BASE + i[8:0];
      end
    end
  end

  // pendable service and tick ranked against the irq candidate by their 2-bit priority; nmi always wins
  reg [8:0] pending_vector;
  reg [2:0] best_prio;
  always @* begin
    pending_vector = 9'h000;
    best_prio      = 3'h7;
    if (irq_found) begin
      pending_vector = irq_vec;
      best_prio      = {1'b0, (|irq_hi) ? 2'h0 : 2'h3};
    end
    if (psv_pend && ({1'b0, pendable_service_priority} <= best_prio)) begin
      pending_vector = `EXC_PSV;
      best_prio      = {1'b0, pendable_service_priority};
    end
    if (tick_pend && ({1'b0, tick_handler_priority} <= best_prio)) begin
      pending_vector = `EXC_TICK;
      best_prio      = {1'b0, tick_handler_priority};
    end
    if (nmi_pend) begin
      pending_vector = `EXC_NMI;
    end
  end

  wire interrupt_pending_flag = (|irq_pending) | psv_pend | tick_pend;
  wire debug_exit_preempt     = debug_halted && (pending_vector != 9'h000);

  // ****************************************************************
  // pending state of nmi, pendable service and tick
  // ****************************************************************
  wire nmi_taken  = exc_enter && (exc_enter_num == `EXC_NMI);
  wire psv_taken  = exc_enter && (exc_enter_num == `EXC_PSV);
  wire tick_taken = exc_enter && (exc_enter_num == `EXC_TICK);
  wire psv_set_w  = wr_pend && reg_wdata[`BIT_PSV_SET];
  wire tick_set_w = wr_pend && reg_wdata[`BIT_TICK_SET];
  wire psv_clr_w  = wr_pend && reg_wdata[`BIT_PSV_CLR] && !reg_wdata[`BIT_PSV_SET];
  wire tick_clr_w = wr_pend && reg_wdata[`BIT_TICK_CLR] && !reg_wdata[`BIT_TICK_SET];

  // a clear only counts when the matching set bit is written as zero in
  // the same access, so a read-modify-write that carries a set bit back
  // can never drop a pending request by accident.
  // handler entry clears the bit, but a request in that very cycle wins.
  // sets win over clears so an event in the clearing cycle is kept
  always @(posedge sys_clk) begin
    if (rst) begin
      nmi_pend  <= 1'b0;
      psv_pend  <= 1'b0;
      tick_pend <= 1'b0;
    end else begin
      if (nmi_req || (wr_pend && reg_wdata[`BIT_NMI_SET])) begin
        nmi_pend <= 1'b1;
      end else if (nmi_taken) begin
        nmi_pend <= 1'b0;
      end
      if (psv_set_w) begin
        psv_pend <= 1'b1;
      end else if (psv_clr_w || psv_taken) begin
        psv_pend <= 1'b0;
      end
      if (tick_set_w || tick_event) begin
        tick_pend <= 1'b1;
      end else if (tick_clr_w || tick_taken) begin
        tick_pend <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // active vector tracking
  // ****************************************************************
  // nesting is not tracked here: the core knows its own stack of
  // handlers and tells us where each return lands.
  // the core reports the vector it returns to; zero means thread mode
  always @(posedge sys_clk) begin
    if (rst) begin
      active_vector_ff <= 9'h000;
    end else if (exc_enter) begin
      active_vector_ff <= exc_enter_num;
    end else if (exc_return) begin
      active_vector_ff <= exc_return_to;
    end
  end

  // ****************************************************************
  // sleep control and priority registers
  // ****************************************************************
  // only the implemented bits are stored; every other bit of these words
  // reads zero because the read mux places nothing there
  always @(posedge sys_clk) begin
    if (rst) begin
      wake_on_pending_ff        <= 1'b0;
      deep_sleep_select_ff      <= 1'b0;
      sleep_on_return_ff        <= 1'b0;
      supervisor_call_priority  <= `RST_PRIO;
      pendable_service_priority <= `RST_PRIO;
      tick_handler_priority     <= `RST_PRIO;
    end else begin
      if (wr_sleep) begin
        wake_on_pending_ff   <= reg_wdata[`BIT_WAKE_ON_PEND];
        deep_sleep_select_ff <= reg_wdata[`BIT_DEEP_SLEEP];
        sleep_on_return_ff   <= reg_wdata[`BIT_SLEEP_ON_RET];
      end
      if (wr_pra) begin
        supervisor_call_priority <= reg_wdata[`PRIO_HI_HI:`PRIO_HI_LO];
      end
      if (wr_prb) begin
        tick_handler_priority     <= reg_wdata[`PRIO_HI_HI:`PRIO_HI_LO];
        pendable_service_priority <= reg_wdata[`PRIO_LO_HI:`PRIO_LO_LO];
      end
    end
  end

  // ****************************************************************
  // wake and event logic
  // ****************************************************************
  // a newly pending source counts once, at its rising edge only
  wire [NUM_IRQ-1:0] irq_new = irq_pending & ~irq_pend_prev_ff;
  wire [NUM_IRQ-1:0] irq_wake_mask = wake_on_pending_ff ? {NUM_IRQ{1'b1}} : irq_enabled;
  wire pend_event  = |(irq_new & irq_wake_mask);
  wire any_event   = pend_event | send_event_instruction | ext_event | tick_event;
  wire enabled_irq = |irq_ready;
  wire wfi_wake    = enabled_irq | nmi_pend | (wake_on_pending_ff & (|irq_pending));
  wire ret_sleep   = exc_return && (exc_return_to == 9'h000) && sleep_on_return_ff;
  wire wait_event_wake = any_event | event_latched | nmi_pend;

  reg [1:0] nxt_state;
  reg       nxt_wait_event;
  reg       nxt_wake;
  // wait-for-event consumes a latched event instead of sleeping; a sleep
  // request that meets a wake source in the same cycle is not entered at
  // all, which avoids a one-cycle sleep with a pointless wake pulse; only a
  // wait-for-event with nmi_pend set still enters sleep for one cycle
  always @* begin
    nxt_state      = state_ff;
    nxt_wait_event = wait_event_mode_ff;
    nxt_wake       = 1'b0;
    case (state_ff)
      ST_RUN: begin
        if (wait_for_event_req && !(event_latched || any_event)) begin
          nxt_state      = ST_SLEEP;
          nxt_wait_event = 1'b1;
        end else if ((sleep_req || ret_sleep) && !wfi_wake) begin
          nxt_state      = ST_SLEEP;
          nxt_wait_event = 1'b0;
        end
      end
      ST_SLEEP: begin
        if (wait_event_mode_ff ? wait_event_wake : wfi_wake) begin
          nxt_state = ST_RUN;
          nxt_wake  = 1'b1;
        end
      end
      default: nxt_state = ST_RUN;
    endcase
  end

  always @(posedge sys_clk) begin
    if (rst) begin
      state_ff           <= ST_RUN;
      wait_event_mode_ff <= 1'b0;
      sleeping         <= 1'b0;
      deep_sleep       <= 1'b0;
      wake_pulse       <= 1'b0;
      event_latched    <= 1'b0;
      irq_pend_prev_ff <= {NUM_IRQ{1'b0}};
    end else begin
      state_ff           <= nxt_state;
      wait_event_mode_ff <= nxt_wait_event;
      sleeping         <= (nxt_state == ST_SLEEP);
      deep_sleep       <= (nxt_state == ST_SLEEP) && deep_sleep_select_ff;
      wake_pulse       <= nxt_wake;
      irq_pend_prev_ff <= irq_pending;
      // latch events seen outside a wait-for-event sleep; a wait-for-event consumes it
      // an event that wakes a waiting core is used up by that wake and
      // is not latched again, or the next wait would fall straight through
      if (any_event && !(state_ff == ST_SLEEP && wait_event_mode_ff)) begin
        event_latched <= 1'b1;
      end else if (wait_for_event_req ||
                   (state_ff == ST_SLEEP && wait_event_mode_ff && nxt_wake)) begin
        event_latched <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // read port; data one cycle after the strobe, zero otherwise
  // ****************************************************************
  // the mux is built from the address alone; the read strobe only gates
  // the registered copy, so the output is zero in every cycle that does
  // not follow a read. write-only clear bits have no read source and so
  // read zero like the reserved bits.
  reg [31:0] rd_mux;
  always @* begin
    rd_mux = 32'h00000000;
    case (reg_addr)
      `OFS_CORE_IDENTITY:
        rd_mux = {IMPL_CODE, 4'h0, ARCH_CODE, PART_CODE, REV_CODE};
      `OFS_EXC_PEND_STATE: begin
        rd_mux[`BIT_NMI_SET]                 = nmi_pend;
        rd_mux[`BIT_PSV_SET]                 = psv_pend;
        rd_mux[`BIT_TICK_SET]                = tick_pend;
        rd_mux[`BIT_PREEMPT]                 = debug_exit_preempt;
        rd_mux[`BIT_IRQ_PEND]                = interrupt_pending_flag;
        rd_mux[`PEND_VEC_HI:`PEND_VEC_LO]    = pending_vector;
        rd_mux[`ACT_VEC_HI:`ACT_VEC_LO]      = active_vector_ff;
      end
      `OFS_SLEEP_CONTROL: begin
        rd_mux[`BIT_WAKE_ON_PEND] = wake_on_pending_ff;
        rd_mux[`BIT_DEEP_SLEEP]   = deep_sleep_select_ff;
        rd_mux[`BIT_SLEEP_ON_RET] = sleep_on_return_ff;
      end
      `OFS_HANDLER_PRIO_A:
        rd_mux[`PRIO_HI_HI:`PRIO_HI_LO] = supervisor_call_priority;
      `OFS_HANDLER_PRIO_B: begin
        rd_mux[`PRIO_HI_HI:`PRIO_HI_LO] = tick_handler_priority;
        rd_mux[`PRIO_LO_HI:`PRIO_LO_LO] = pendable_service_priority;
      end
      `OFS_CORE_EVENTS: begin
        rd_mux[0] = event_latched;
        rd_mux[1] = sleeping;
      end
      default: rd_mux = 32'h00000000;
    endcase
  end

  // little-endian: bit 0 of the word is byte 0 bit 0; no swapping path exists
  always @(posedge sys_clk) begin
    if (rst) begin
      reg_rdata <= 32'h00000000;
    end else begin
      reg_rdata <= reg_rd ? rd_mux : 32'h00000000;
    end
  end

endmodule // system_control_block_regs

// ===== rtl/sys_ctrl_defs.vh
`ifndef SYS_CTRL_DEFS_VH
`define SYS_CTRL_DEFS_VH

// ****************************************************************
// register offsets within the system control space
// ****************************************************************
`define CONTROL_SPACE_BASE   32'he000e000
`define OFS_CORE_IDENTITY    12'hd00
`define OFS_EXC_PEND_STATE   12'hd04
`define OFS_SLEEP_CONTROL    12'hd10
`define OFS_HANDLER_PRIO_A   12'hd1c
`define OFS_HANDLER_PRIO_B   12'hd20
`define OFS_CORE_EVENTS      12'hd80

// ****************************************************************
// exception_pend_state fields
// ****************************************************************
`define BIT_NMI_SET          31
`define BIT_PSV_SET          28
`define BIT_PSV_CLR          27
`define BIT_TICK_SET         26
`define BIT_TICK_CLR         25
`define BIT_PREEMPT          23
`define BIT_IRQ_PEND         22
`define PEND_VEC_HI          20
`define PEND_VEC_LO          12
`define ACT_VEC_HI           8
`define ACT_VEC_LO           0

// ****************************************************************
// sleep_control fields and priority fields
// ****************************************************************
`define BIT_WAKE_ON_PEND     4
`define BIT_DEEP_SLEEP       2
`define BIT_SLEEP_ON_RET     1
`define PRIO_HI_HI           31
`define PRIO_HI_LO           30
`define PRIO_LO_HI           23
`define PRIO_LO_LO           22

// ****************************************************************
// exception numbers and reset values
// ****************************************************************
`define EXC_NMI              9'h002
`define EXC_PSV              9'h00e
`define EXC_TICK             9'h00f
`define EXC_IRQ_BASE         9'h010
`define RST_SLEEP_CTRL       3'h0
`define RST_PRIO             2'h0

`endif

// ===== sim/sys_ctrl_monitor.sv
`timescale 1ns/1ps
`include "sys_ctrl_defs.vh"
// ****
// register bank checker
// ****
module sys_ctrl_monitor (
  input wire        sys_clk,
  input wire        rst,
  input wire [11:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire        reg_wr,
  input wire        reg_rd,
  input wire [31:0] reg_rdata,
  input wire        nmi_req,
  input wire        exc_enter,
  input wire [8:0]  exc_enter_num,
  input wire        wait_for_event_req,
  input wire        sleeping,
  input wire        deep_sleep,
  input wire        wake_pulse,
  input wire        nmi_pend,
  input wire        psv_pend,
  input wire        event_latched
);
  logic sel_ff;
  wire  pw = reg_wr && reg_addr == `OFS_EXC_PEND_STATE;
  // shadow of the deep select bit, so sleep depth can be judged at entry
  always @(posedge sys_clk) begin
    if (rst)
      sel_ff <= 1'b0;
    else if (reg_wr && reg_addr == `OFS_SLEEP_CONTROL)
      sel_ff <= reg_wdata[2];
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  a_rdata_quiet: assert property (
    !$past(reg_rd) |-> reg_rdata == 32'h0) else $error("read data not idle");
  a_nmi_set: assert property (
    pw && reg_wdata[31] |=> nmi_pend) else $error("nmi set ignored");
  a_psv_set: assert property (
    pw && reg_wdata[28] |=> psv_pend) else $error("pendable set ignored");
  a_psv_clear: assert property (
    pw && reg_wdata[27] && !reg_wdata[28] |=> !psv_pend) else $error("pendable clear ignored");
  a_psv_sw_only: assert property (
    $rose(psv_pend) |-> $past(pw) && $past(reg_wdata[28])) else $error("pendable set by hw");
  a_nmi_entry: assert property (
    exc_enter && exc_enter_num == `EXC_NMI && !nmi_req && !(pw && reg_wdata[31])
    |=> !nmi_pend) else $error("nmi entry kept pending");
  a_wait_latched: assert property (
    wait_for_event_req && event_latched |=> !sleeping) else $error("slept with latched event");
  a_deep_depth: assert property (
    $rose(sleeping) |-> deep_sleep == sel_ff) else $error("wrong sleep depth");
  a_wake_pulse: assert property (
    $fell(sleeping) |-> wake_pulse ##1 !wake_pulse) else $error("bad wake pulse");
endmodule // sys_ctrl_monitor

bind system_control_block_regs sys_ctrl_monitor mon (.sys_clk(sys_clk), .rst(rst),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .nmi_req(nmi_req), .exc_enter(exc_enter),
  .exc_enter_num(exc_enter_num), .wait_for_event_req(wait_for_event_req),
  .sleeping(sleeping),
  .deep_sleep(deep_sleep), .wake_pulse(wake_pulse), .nmi_pend(nmi_pend),
  .psv_pend(psv_pend), .event_latched(event_latched));

// ===== sim/sw_core.sv
`timescale 1ns/1ps
// ****
// software side: register bus master
// ****
module sw_core (
  input  wire         sys_clk,
  input  wire  [31:0] reg_rdata,
  output logic [11:0] reg_addr,
  output logic [31:0] reg_wdata,
  output logic        reg_wr,
  output logic        reg_rd
);
  // idle bus at time zero
  initial begin
    reg_addr = 12'h000;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // one strobe cycle; released lines show garbage so stale values are never trusted
  task wr(input [11:0] a, input [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
    #1;
  endtask
  // data stands only in the cycle after the strobe
  task rd(input [11:0] a, output [31:0] d);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    #1 d = reg_rdata;
  endtask
endmodule // sw_core

// ===== sim/tb_top.sv
`timescale 1ns/1ps
`include "sys_ctrl_defs.vh"
module tb_top;
  typedef struct {logic [11:0] a; logic [31:0] w; logic [31:0] e;} row_t;
  logic        sys_clk      = 1'b0;
  logic        rst          = 1'b1;
  logic [7:0]  pls          = 8'h00;
  logic        debug_halted = 1'b0;
  logic [8:0]  exc_num      = 9'h000;
  logic [31:0] irq_pending  = 32'h0;
  logic [31:0] irq_enabled  = 32'h0;
  logic [31:0] irq_prio_hi  = 32'h0;
  logic [31:0] d;
  wire  [11:0] reg_addr;
  wire  [31:0] reg_wdata;
  wire  [31:0] reg_rdata;
  wire         reg_wr;
  wire         reg_rd;
  wire         sleeping;
  wire         deep_sleep;
  wire         wake_pulse;
  wire         nmi_pend;
  wire         psv_pend;
  wire         tick_pend;
  wire         event_latched;
  wire  [5:0]  prio;
  int          errors       = 0;
  int          comparisons  = 0;
  logic [11:0] rst_ofs [4]  = '{12'hd04, 12'hd10, 12'hd1c, 12'hd20};
  // address, write value, read-back value
  row_t        rows [6]     = '{'{12'hd10, 32'hffffffff, 32'h00000016},
                                '{12'hd1c, 32'hffffffff, 32'hc0000000},
                                '{12'hd20, 32'hffffffff, 32'hc0c00000},
                                '{12'hd00, 32'hffffffff, 32'h5a031231},
                                '{12'hd30, 32'hffffffff, 32'h00000000},
                                '{12'hd20, 32'h00400000, 32'h00400000}};

  always #20 sys_clk = ~sys_clk;

  sw_core core (.sys_clk(sys_clk), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd));

  // pulse lines share one vector so a single task drives them all
  system_control_block_regs uut (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .nmi_req(pls[6]), .tick_event(pls[0]), .irq_pending(irq_pending),
    .irq_enabled(irq_enabled), .irq_prio_hi(irq_prio_hi), .exc_enter(pls[4]),
    .exc_enter_num(exc_num), .exc_return(pls[5]), .exc_return_to(exc_num),
    .debug_halted(debug_halted), .sleep_req(pls[7]), .wait_for_event_req(pls[1]),
    .send_event_instruction(pls[2]), .ext_event(pls[3]), .sleeping(sleeping),
    .deep_sleep(deep_sleep), .wake_pulse(wake_pulse), .nmi_pend(nmi_pend),
    .psv_pend(psv_pend), .tick_pend(tick_pend), .event_latched(event_latched),
    .supervisor_call_priority(prio[5:4]), .pendable_service_priority(prio[3:2]),
    .tick_handler_priority(prio[1:0]));

  task chk(input string name, input [31:0] exp, input [31:0] got);
    comparisons = comparisons + 1;
    if (got !== exp) begin
      errors = errors + 1;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask

  // one-cycle pulse; returns just after the sampling edge so outputs have landed
  task pulse(input [7:0] m);
    pls <= m;
    @(posedge sys_clk);
    pls <= 8'h00;
    #1;
  endtask

  task stop_test;
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // watchdog: the whole sequence needs well under 1000 cycles
  initial begin
    #400000;
    errors = errors + 1;
    stop_test();
  end

  initial begin
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    foreach (rows[i]) begin
      core.wr(rows[i].a, rows[i].w);
      core.rd(rows[i].a, d);
      chk("row", rows[i].e, d);
    end
    chk("prio", 32'h34, {26'h0, prio});
    // handler return with sleep-on-return set, then wake on a disabled irq
    exc_num <= `EXC_IRQ_BASE;
    pulse(8'h10);
    exc_num <= 9'h000;
    pulse(8'h20);
    chk("sleep", 32'h3, {sleeping, deep_sleep});
    irq_pending <= 32'h20;
    @(posedge sys_clk);
    #1 chk("wake", 32'h1, {sleeping, wake_pulse});
    // the tagged line outranks the lower-numbered untagged one
    irq_pending <= 32'h18;
    irq_enabled <= 32'h18;
    irq_prio_hi <= 32'h10;
    debug_halted <= 1'b1;
    repeat (2) @(posedge sys_clk);
    core.rd(`OFS_EXC_PEND_STATE, d);
    chk("vec", 32'h00c14000, d & 32'h00dff1ff);
    irq_enabled <= 32'h0;
    repeat (2) @(posedge sys_clk);
    core.rd(`OFS_EXC_PEND_STATE, d);
    chk("vec_off", 32'h0, d & 32'h001ff000);
    irq_pending <= 32'h0;
    debug_halted <= 1'b0;
    // pending bits: set, set beside clear, proper clear
    core.wr(`OFS_EXC_PEND_STATE, 32'h94000000);
    chk("pend", 32'h7, {nmi_pend, psv_pend, tick_pend});
    core.rd(`OFS_EXC_PEND_STATE, d);
    chk("state", 32'h94402000, d & 32'hff7fffff);
    core.wr(`OFS_EXC_PEND_STATE, 32'h18000000);
    chk("set_wins", 32'h1, psv_pend);
    core.wr(`OFS_EXC_PEND_STATE, 32'h0a000000);
    chk("cleared", 32'h4, {nmi_pend, psv_pend, tick_pend});
    // nmi handler entry clears pending; a new request pends again
    exc_num <= `EXC_NMI;
    pulse(8'h10);
    chk("nmi_entry", 32'h0, nmi_pend);
    core.rd(`OFS_EXC_PEND_STATE, d);
    chk("active", 32'h2, d & 32'h1ff);
    pulse(8'h40);
    chk("nmi_again", 32'h1, nmi_pend);
    pulse(8'h10);
    // event latching and wake-up from wait-for-event
    pulse(8'h01);
    chk("latched", 32'h3, {psv_pend, tick_pend, event_latched});
    core.rd(`OFS_CORE_EVENTS, d);
    chk("events", 32'h1, d);
    core.wr(`OFS_EXC_PEND_STATE, 32'h02000000);
    pulse(8'h02);
    chk("no_sleep", 32'h0, {sleeping, event_latched});
    pulse(8'h02);
    chk("wait_sleep", 32'h1, sleeping);
    pulse(8'h04);
    chk("send_wake", 32'h1, {sleeping, wake_pulse});
    pulse(8'h02);
    pulse(8'h08);
    chk("ext", 32'h1, {sleeping, wake_pulse});
    // second reset in mid-run restores every writable register
    rst <= 1'b1;
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    foreach (rst_ofs[i]) begin
      core.rd(rst_ofs[i], d);
      chk("reset", 32'h0, d);
    end
    stop_test();
  end
endmodule // tb_top
